// [include/rpb_pkg.sv]
`default_nettype none
package rpb_pkg;
   // Geometry
   localparam int NCS = 4;                   // Coordinate systems
   localparam int CSW = 2;
   localparam int AW  = 8;                   // Ring memory address width
   localparam int SW  = 9;                   // Word and line counters
   localparam logic [SW-1:0] MEM_WORDS = 9'h100;
   localparam logic [SW-1:0] ZERO_CNT  = 9'h000;
   localparam logic [SW-1:0] ONE_CNT   = 9'h001;

   // Register byte offsets
   localparam logic [7:0] OFF_CMD    = 8'h00;
   localparam logic [7:0] OFF_CS_SEL = 8'h04;
   localparam logic [7:0] OFF_LIMIT  = 8'h08;
   localparam logic [7:0] OFF_REFILL = 8'h0c;
   localparam logic [7:0] OFF_SEG    = 8'h10;
   localparam logic [7:0] OFF_WORD   = 8'h14;
   localparam logic [7:0] OFF_LEND   = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   localparam logic [7:0] OFF_REMAIN = 8'h20;
   localparam logic [7:0] OFF_RUNST  = 8'h24;

   // Command register fields
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_SIZE_LSB = 8;

   // Status register fields
   localparam int ST_OPEN = 0;
   localparam int ST_CAPT = 1;
   localparam int ST_ERR  = 2;
   localparam int ST_REQ  = 3;
   localparam int ST_FULL = 4;                // NCS bits
   localparam int ST_ALOC = 8;                // NCS bits

   // Reset values
   localparam logic [SW-1:0] LIMIT_RST  = 9'h010;
   localparam logic [SW-1:0] REFILL_RST = 9'h008;
   localparam logic [15:0]   SEG_RST    = 16'h0000;

   typedef enum logic [3:0] {
      OP_NOP     = 4'h0,
      OP_ALLOC   = 4'h1,
      OP_OPEN    = 4'h2,
      OP_CLOSE   = 4'h3,
      OP_FREE    = 4'h4,
      OP_CAPT    = 4'h5,
      OP_UNCAPT  = 4'h6,
      OP_REWIND  = 4'h7,
      OP_RUN     = 4'h8,
      OP_QUIT    = 4'h9,
      OP_ABORT   = 4'ha
   } rpb_op_t;

   typedef enum logic [2:0] {
      PS_IDLE   = 3'b000,
      PS_READY  = 3'b001,
      PS_RUN    = 3'b010,
      PS_STARVE = 3'b011,
      PS_ABORT  = 3'b100
   } rpb_prog_t;

   typedef struct packed {
      logic          psel;
      logic          penable;
      logic          pwrite;
      logic [7:0]    paddr;
      logic [31:0]   pwdata;
   } rpb_apb_t;

   typedef struct packed {
      logic          valid;                  // A line begins execution
      logic [CSW-1:0] cs;
      logic [SW-1:0] words;                  // Words held by that line
      logic          late;                   // Move time came before its data
      logic          decel;                  // Deceleration to stop has begun
   } rpb_exec_t;

   typedef struct packed {
      logic          alloc;
      logic [SW-1:0] size;
      logic [SW-1:0] used;
      logic [SW-1:0] pend;
      logic [SW-1:0] lines;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic          req;
      rpb_prog_t     st;
   } rpb_cs_t;

   typedef struct packed {
      rpb_cs_t [NCS-1:0] cs;
      logic              open;
      logic              capture;
      logic [CSW-1:0]    sel;
      logic [SW-1:0]     limit;
      logic [SW-1:0]     refill;
      logic [15:0]       seg;
      logic              err;
      logic              reeval;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
      logic              stop;
      logic              blend;
      logic              out_req;            // Pin copies, one flop each
      logic              out_req_n;
      logic [NCS-1:0]    out_full;
      logic [NCS-1:0]    out_run;
   } rpb_state_t;
endpackage
`default_nettype wire

// [hdl/rpb_ring.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - One append-while-executing ring per coordinate system
// - Allocation sizes ring in words, one per value
// - Allocate only without capture, higher systems free
// - Run accepted open or closed, waits when empty
// - Open enables all rings, lines go to addressed
// - Open entry treats commands as buffered lines
// - Remaining query returns lines ahead of execution
// - Request high while addressed ring wants lines
// - Complement of request on panel connector
// - Per-system full status bit mirrors request
// - Line written drops request, re-raise below limit
// - Open or reselect drops request, re-raise below limit
// - After executed line raise below refill threshold
// - Running dry is no error, program suspends
// - Nonzero segmentation blends a timely new line
// - Close blocks entry, execution continues
// - Free erases ring and releases its memory
// - Late trajectory data aborts and stops motors
module rpb_ring
   import rpb_pkg::*;
(
   // Clock and reset
   input  wire logic             CLK,
   input  wire logic             RST,
   // APB slave
   input  wire rpb_apb_t         APB_REQ,
   output var  logic             PREADY,
   output var  logic [31:0]      PRDATA,
   output var  logic             PSLVERR,
   // Execution side
   input  wire rpb_exec_t        EXEC,
   output var  logic [31:0]      EXEC_WORD,
   output var  logic             STOP_MOTORS,
   output var  logic             BLEND_NEW,
   // Handshake lines
   output var  logic             BUFFER_REQUEST,
   output var  logic             BUFFER_REQUEST_N,
   output var  logic [NCS-1:0]   BUFFER_FULL,
   output var  logic [NCS-1:0]   RUN_ACTIVE
);

   rpb_state_t           s_r;
   rpb_state_t           s_nxt;
   logic [31:0]          mem [0:(1<<AW)-1];
   logic [31:0]          exec_word_r;
   logic                 mem_we;
   logic [AW-1:0]        mem_wa;
   logic [AW-1:0]        mem_ra;

   // Words reserved by this system and every higher one
   function automatic logic [SW-1:0] taken_from(input rpb_state_t s, input int unsigned n);
      logic [SW-1:0] acc;
      acc = ZERO_CNT;
      for (int k = 0; k < NCS; k++) begin
         if (k >= n && s.cs[k].alloc) begin
            acc = acc + s.cs[k].size;
         end
      end
      return acc;
   endfunction

   // Physical word of a ring-relative pointer; rings stack downward
   function automatic logic [AW-1:0] phys(input rpb_state_t s, input int unsigned n,
                                          input logic [AW-1:0] ptr);
      logic [SW-1:0] base;
      base = MEM_WORDS - taken_from(s, n);
      return AW'(base + {1'b0, ptr});
   endfunction

   // Ring-relative pointer advance with wrap at the ring size
   function automatic logic [AW-1:0] adv(input logic [AW-1:0] ptr, input logic [SW-1:0] by,
                                         input logic [SW-1:0] size);
      logic [SW:0] sum;
      sum = {2'b00, ptr} + {1'b0, by};
      if (sum >= {1'b0, size}) begin
         sum = sum - {1'b0, size};
      end
      return AW'(sum);
   endfunction

   // Program counts as running while it executes or waits for lines
   function automatic logic is_active(input rpb_prog_t st);
      return (st == PS_RUN) || (st == PS_STARVE);
   endfunction

   // Entry is possible only into an open, reserved ring
   function automatic logic can_enter(input rpb_state_t s, input logic [CSW-1:0] n);
      return s.open && s.cs[n].alloc;
   endfunction

   logic          wr_acc;
   logic          setup_ph;
   logic [7:0]    addr;
   logic [31:0]   wd;
   rpb_op_t       op;
   logic [SW-1:0] arg;
   logic          higher_alloc;

   assign wr_acc = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & s_r.pready;
   assign setup_ph = APB_REQ.psel & ~APB_REQ.penable;
   assign addr   = APB_REQ.paddr;
   assign wd     = APB_REQ.pwdata;
   assign op     = rpb_op_t'(wd[CMD_OP_LSB +: 4]);
   assign arg    = wd[CMD_SIZE_LSB +: SW];

   // Any ring above the addressed one already reserved
   always_comb begin
      higher_alloc = 1'b0;
      for (int k = 0; k < NCS; k++) begin
         if (k > int'(s_r.sel) && s_r.cs[k].alloc) begin
            higher_alloc = 1'b1;
         end
      end
   end

   // Next state of the whole block
   always_comb begin
      logic [CSW-1:0] c;
      logic [SW-1:0]  left;
      s_nxt        = s_r;
      c            = s_r.sel;
      left         = ZERO_CNT;
      mem_we       = 1'b0;
      mem_wa       = phys(s_r, int'(c), s_r.cs[c].wr_ptr);
      mem_ra       = phys(s_r, int'(EXEC.cs), s_r.cs[EXEC.cs].rd_ptr);
      s_nxt.stop   = 1'b0;
      s_nxt.blend  = 1'b0;
      s_nxt.reeval = 1'b0;
      // Answer stands for the access cycle only, so a stale error never lingers
      s_nxt.prdata  = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      // Zero-wait slave: ready is raised by the setup cycle
      s_nxt.pready = setup_ph;

      // Second half of a drop-and-recheck: raise only below the limit
      if (s_r.reeval) begin
         s_nxt.cs[c].req = (s_r.cs[c].lines < s_r.limit);
      end

      // Execution of the next line begins
      if (EXEC.valid && s_r.cs[EXEC.cs].st == PS_RUN) begin
         if (s_r.cs[EXEC.cs].lines != ZERO_CNT) begin
            left = s_r.cs[EXEC.cs].lines - ONE_CNT;
            s_nxt.cs[EXEC.cs].lines  = left;
            s_nxt.cs[EXEC.cs].used   = s_r.cs[EXEC.cs].used - EXEC.words;
            s_nxt.cs[EXEC.cs].rd_ptr = adv(s_r.cs[EXEC.cs].rd_ptr, EXEC.words,
                                           s_r.cs[EXEC.cs].size);
            if (left < s_r.refill) begin
               s_nxt.cs[EXEC.cs].req = 1'b1;
            end
            if (left == ZERO_CNT) begin
               s_nxt.cs[EXEC.cs].st = PS_STARVE;
            end
         end else begin
            s_nxt.cs[EXEC.cs].st = PS_STARVE;
         end
      end

      // Trajectory data missed its start time
      if (EXEC.late && is_active(s_r.cs[EXEC.cs].st)) begin
         s_nxt.cs[EXEC.cs].st = PS_ABORT;
         s_nxt.stop           = 1'b1;
      end

      // Register writes take effect at the access edge only
      if (wr_acc) begin
         case (addr)
            OFF_CMD: begin
               s_nxt.err = 1'b0;
               case (op)
                  OP_ALLOC: begin
                     // Reservation stacks from the top, so order matters
                     if (!s_r.capture && !higher_alloc && !s_r.cs[c].alloc &&
                         arg != ZERO_CNT && arg <= MEM_WORDS - taken_from(s_r, 0)) begin
                        s_nxt.cs[c].alloc  = 1'b1;
                        s_nxt.cs[c].size   = arg;
                        s_nxt.cs[c].used   = ZERO_CNT;
                        s_nxt.cs[c].pend   = ZERO_CNT;
                        s_nxt.cs[c].lines  = ZERO_CNT;
                        s_nxt.cs[c].wr_ptr = '0;
                        s_nxt.cs[c].rd_ptr = '0;
                     end else begin
                        s_nxt.err = 1'b1;
                     end
                  end
                  OP_OPEN: begin
                     if (taken_from(s_r, 0) != ZERO_CNT) begin
                        s_nxt.open      = 1'b1;
                        s_nxt.cs[c].req = 1'b0;
                        s_nxt.reeval    = 1'b1;
                     end else begin
                        s_nxt.err = 1'b1;
                     end
                  end
                  OP_CLOSE: begin
                     s_nxt.open = 1'b0;
                  end
                  OP_FREE: begin
                     s_nxt.cs[c] = '0;
                  end
                  OP_CAPT: begin
                     s_nxt.capture = 1'b1;
                  end
                  OP_UNCAPT: begin
                     s_nxt.capture = 1'b0;
                  end
                  OP_REWIND: begin
                     // While open the same text is an axis move, not ours
                     if (!s_r.open && s_r.cs[c].alloc) begin
                        s_nxt.cs[c].st = PS_READY;
                     end else begin
                        s_nxt.err = 1'b1;
                     end
                  end
                  OP_RUN: begin
                     if (s_r.cs[c].st == PS_READY) begin
                        s_nxt.cs[c].st = (s_r.cs[c].lines == ZERO_CNT) ? PS_STARVE
                                                                        : PS_RUN;
                     end else begin
                        s_nxt.err = 1'b1;
                     end
                  end
                  OP_QUIT, OP_ABORT: begin
                     if (s_r.cs[c].st != PS_IDLE) begin
                        s_nxt.cs[c].st = PS_READY;
                     end
                     s_nxt.stop = (op == OP_ABORT);
                  end
                  default: begin
                     s_nxt.err = 1'b1;
                  end
               endcase
            end
            OFF_CS_SEL: begin
               s_nxt.sel                    = wd[CSW-1:0];
               s_nxt.cs[wd[CSW-1:0]].req    = 1'b0;
               s_nxt.reeval                 = 1'b1;
            end
            OFF_LIMIT: begin
               s_nxt.limit = wd[SW-1:0];
            end
            OFF_REFILL: begin
               s_nxt.refill = wd[SW-1:0];
            end
            OFF_SEG: begin
               s_nxt.seg = wd[15:0];
            end
            OFF_WORD: begin
               // One value of a line takes one word of the ring
               if (can_enter(s_r, c) &&
                   s_r.cs[c].used + s_r.cs[c].pend < s_r.cs[c].size) begin
                  mem_we             = 1'b1;
                  s_nxt.cs[c].wr_ptr = adv(s_r.cs[c].wr_ptr, ONE_CNT, s_r.cs[c].size);
                  s_nxt.cs[c].pend   = s_r.cs[c].pend + ONE_CNT;
               end else begin
                  s_nxt.err = 1'b1;
               end
            end
            OFF_LEND: begin
               if (can_enter(s_r, c) && s_r.cs[c].pend != ZERO_CNT) begin
                  s_nxt.cs[c].lines = s_nxt.cs[c].lines + ONE_CNT;
                  s_nxt.cs[c].used  = s_nxt.cs[c].used + s_r.cs[c].pend;
                  s_nxt.cs[c].pend  = ZERO_CNT;
                  s_nxt.cs[c].req   = 1'b0;
                  s_nxt.reeval      = 1'b1;
                  if (s_r.cs[c].st == PS_STARVE) begin
                     s_nxt.cs[c].st = PS_RUN;
                     // Still moving: splice in without a stop
                     s_nxt.blend    = (s_r.seg != 16'h0000) && !EXEC.decel;
                  end
               end else begin
                  s_nxt.err = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      // Read data and error answer are latched in the setup cycle
      if (setup_ph) begin
         s_nxt.prdata  = 32'h0000_0000;
         s_nxt.pslverr = 1'b0;
         case (addr)
            OFF_CMD, OFF_WORD, OFF_LEND: begin
               s_nxt.prdata = 32'h0000_0000;
            end
            OFF_CS_SEL: begin
               s_nxt.prdata[CSW-1:0] = s_r.sel;
            end
            OFF_LIMIT: begin
               s_nxt.prdata[SW-1:0] = s_r.limit;
            end
            OFF_REFILL: begin
               s_nxt.prdata[SW-1:0] = s_r.refill;
            end
            OFF_SEG: begin
               s_nxt.prdata[15:0] = s_r.seg;
            end
            OFF_STATUS: begin
               s_nxt.prdata[ST_OPEN] = s_r.open;
               s_nxt.prdata[ST_CAPT] = s_r.capture;
               s_nxt.prdata[ST_ERR]  = s_r.err;
               s_nxt.prdata[ST_REQ]  = s_r.cs[c].req;
               for (int k = 0; k < NCS; k++) begin
                  s_nxt.prdata[ST_FULL + k] = ~s_r.cs[k].req;
                  s_nxt.prdata[ST_ALOC + k] = s_r.cs[k].alloc;
               end
            end
            OFF_REMAIN: begin
               s_nxt.prdata[SW-1:0] = s_r.cs[c].lines;
            end
            OFF_RUNST: begin
               s_nxt.prdata[2:0] = s_r.cs[c].st;
            end
            default: begin
               s_nxt.pslverr = 1'b1;
            end
         endcase
      end

      // Pin copies taken from the next state keep the old timing,
      // yet no pin hangs on the select mux or an inverter
      s_nxt.out_req   = s_nxt.cs[s_nxt.sel].req;
      s_nxt.out_req_n = ~s_nxt.cs[s_nxt.sel].req;
      for (int k = 0; k < NCS; k++) begin
         s_nxt.out_full[k] = ~s_nxt.cs[k].req;
         s_nxt.out_run[k]  = is_active(s_nxt.cs[k].st);
      end
   end

   // State register
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s_r        <= '0;
         s_r.limit  <= LIMIT_RST;
         s_r.refill <= REFILL_RST;
         s_r.seg    <= SEG_RST;
         // Idle pins: no request, every ring reported full
         s_r.out_req_n <= 1'b1;
         s_r.out_full  <= '1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Ring storage; contents need no reset, pointers guard them
   always_ff @(posedge CLK) begin
      if (mem_we) begin
         mem[mem_wa] <= wd;
      end
      exec_word_r <= mem[mem_ra];
   end

   // Outputs straight from flops
   always_comb begin
      PREADY           = s_r.pready;
      PRDATA           = s_r.prdata;
      PSLVERR          = s_r.pslverr;
      EXEC_WORD        = exec_word_r;
      STOP_MOTORS      = s_r.stop;
      BLEND_NEW        = s_r.blend;
      BUFFER_REQUEST   = s_r.out_req;
      BUFFER_REQUEST_N = s_r.out_req_n;
      BUFFER_FULL      = s_r.out_full;
      RUN_ACTIVE       = s_r.out_run;
   end

endmodule // rpb_ring
`default_nettype wire

// [verif/rpb_ring_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module rpb_ring_asserts
   import rpb_pkg::*;
(
   // Clock and reset
   input  wire logic           CLK,
   input  wire logic           RST,
   // APB slave side
   input  wire rpb_apb_t       APB_REQ,
   input  wire logic           PREADY,
   input  wire logic [31:0]    PRDATA,
   input  wire logic           PSLVERR,
   // Execution side
   input  wire rpb_exec_t      EXEC,
   input  wire logic [31:0]    EXEC_WORD,
   input  wire logic           STOP_MOTORS,
   input  wire logic           BLEND_NEW,
   // Handshake lines
   input  wire logic           BUFFER_REQUEST,
   input  wire logic           BUFFER_REQUEST_N,
   input  wire logic [NCS-1:0] BUFFER_FULL,
   input  wire logic [NCS-1:0] RUN_ACTIVE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   // Completed writes; only these may pull the request line down
   logic wr_done;
   logic le_done;
   assign wr_done = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & PREADY;
   assign le_done = wr_done & (APB_REQ.paddr == OFF_LEND);

   req_complement_a: assert property (BUFFER_REQUEST_N == !BUFFER_REQUEST)
      else $error("request complement mismatch");
   full_mirror_a: assert property (BUFFER_REQUEST |-> !(&BUFFER_FULL))
      else $error("request high with every ring full");
   line_drop_a: assert property (le_done |=> !BUFFER_REQUEST)
      else $error("request not dropped after line end");
   sel_drop_a: assert property (wr_done && APB_REQ.paddr == OFF_CS_SEL |=> !BUFFER_REQUEST)
      else $error("request not dropped after reselect");
   exec_keeps_a: assert property ($fell(BUFFER_REQUEST) |-> $past(wr_done))
      else $error("request fell without a host write");
   blend_cause_a: assert property (BLEND_NEW |-> $past(le_done))
      else $error("blend pulse without a new line");
   late_stop_a: assert property (EXEC.late && RUN_ACTIVE[EXEC.cs] |=> STOP_MOTORS ##1 !STOP_MOTORS)
      else $error("late data did not pulse motor stop");
   zero_wait_a: assert property (APB_REQ.psel && !APB_REQ.penable |=> PREADY)
      else $error("no answer in access cycle");
   err_with_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error response without ready");

   // Main scenarios reached
   cover property (le_done ##2 BUFFER_REQUEST);
   cover property (BLEND_NEW);
   cover property (STOP_MOTORS);
endmodule // rpb_ring_asserts

bind rpb_ring rpb_ring_asserts u_chk (.CLK(CLK), .RST(RST), .APB_REQ(APB_REQ),
   .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EXEC(EXEC),
   .EXEC_WORD(EXEC_WORD), .STOP_MOTORS(STOP_MOTORS), .BLEND_NEW(BLEND_NEW),
   .BUFFER_REQUEST(BUFFER_REQUEST), .BUFFER_REQUEST_N(BUFFER_REQUEST_N),
   .BUFFER_FULL(BUFFER_FULL), .RUN_ACTIVE(RUN_ACTIVE));
`default_nettype wire

// [verif/rpb_host.sv]
`timescale 1ns/1ps
`default_nettype none
module rpb_host
   import rpb_pkg::*;
(
   // Clock
   input  wire logic        CLK,
   // APB master
   output var  rpb_apb_t    apb,
   input  wire logic        PREADY,
   input  wire logic [31:0] PRDATA,
   input  wire logic        PSLVERR
);
   initial apb = '0;

   // One transfer; released lines show the inverse so stale values never match
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge CLK);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge CLK);
      apb.penable <= 1'b1;
      // Look at the answer once settled, never in the edge that launches it
      #1;
      while (PREADY !== 1'b1) begin
         @(posedge CLK);
         #1;
      end
      q = PRDATA;
      err = PSLVERR;
      // Completion edge; release only after it
      @(posedge CLK);
      apb <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
   endtask
endmodule // rpb_host
`default_nettype wire

// [verif/rotary_program_ring_buffer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rotary_program_ring_buffer_tb
   import rpb_pkg::*;
;
   logic           CLK = 1'b0;
   logic           RST = 1'b1;
   rpb_apb_t       apb;
   rpb_exec_t      exec = '0;
   logic           pready, pslverr, blend, stop, req, req_n;
   logic [31:0]    prdata, q, xw;
   logic [7:0]     firsts[$];
   logic [NCS-1:0] full, run;
   logic           e;
   logic           blend_seen = 1'b0;
   int             stops = 0;
   logic [7:0]     rnd = 8'h3e;
   int             failures = 0;
   int             n_tests = 0;
   int             lines = 0;
   int             words[$];

   always #5 CLK = ~CLK;

   rpb_ring u_rpb_ring (.CLK(CLK), .RST(RST), .APB_REQ(apb), .PREADY(pready),
      .PRDATA(prdata), .PSLVERR(pslverr), .EXEC(exec), .EXEC_WORD(xw), .STOP_MOTORS(stop),
      .BLEND_NEW(blend), .BUFFER_REQUEST(req), .BUFFER_REQUEST_N(req_n),
      .BUFFER_FULL(full), .RUN_ACTIVE(run));
   rpb_host u_host (.CLK(CLK), .apb(apb), .PREADY(pready), .PRDATA(prdata),
      .PSLVERR(pslverr));

   // Pulses last one cycle; sampled mid-cycle, away from the launching edge
   always @(negedge CLK) begin
      if (blend === 1'b1) blend_seen <= 1'b1;
      if (stop === 1'b1) stops <= stops + 1;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // More lines are wanted while the count ahead is under the threshold
   function automatic logic want(input int n, input int lim);
      return n < lim;
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a);
      u_host.xfer(1'b0, a, 32'h0, q, e);
   endtask
   task automatic cmd(input rpb_op_t op, input logic [8:0] sz);
      wr(OFF_CMD, {15'h0, sz, 4'h0, op});
   endtask
   // Request settles two edges after the host write
   task automatic settle();
      repeat (2) @(posedge CLK);
      #1;
   endtask
   task automatic pulse(input rpb_exec_t x);
      @(posedge CLK);
      exec <= x;
      @(posedge CLK);
      exec <= '0;
   endtask
   task automatic run_line(input logic [8:0] w);
      pulse('{1'b1, 2'd1, w, 1'b0, 1'b0});
      lines = (lines > 0) ? lines - 1 : 0;
   endtask
   // One program line of n random words
   task automatic load(input int n);
      for (int i = 0; i < n; i++) begin
         rnd = lfsr(rnd);
         if (i == 0) firsts.push_back(rnd);
         wr(OFF_WORD, {24'h0, rnd});
      end
      wr(OFF_LEND, 32'h0);
      words.push_back(n);
      lines++;
   endtask
   // Start the oldest line; its first word shows on the exec port
   task automatic exec_line();
      run_line(9'(words.pop_front()));
      #1;
      chk("exec word", {24'h0, firsts.pop_front()}, xw);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #200us;
      failures++;
      conclude();
   end

   initial begin
      repeat (8) @(posedge CLK);
      RST <= 1'b0;
      #1;
      chk("request", 0, req);
      chk("request_n", 1, req_n);
      chk("full", 32'hf, full);
      rd(OFF_LIMIT);
      chk("limit", 32'(LIMIT_RST), q);
      rd(OFF_REFILL);
      chk("refill", 32'(REFILL_RST), q);
      rd(8'h40);
      chk("unmapped", 1, e);
      // Allocation is refused while a capture store exists
      cmd(OP_CAPT, 9'h0);
      wr(OFF_CS_SEL, 1);
      cmd(OP_ALLOC, 9'h028);
      rd(OFF_STATUS);
      chk("alloc with capture", 32'h4, q & 32'h0f04);
      cmd(OP_UNCAPT, 9'h0);
      cmd(OP_ALLOC, 9'h028);
      rd(OFF_STATUS);
      chk("alloc", 32'h200, q & 32'h0f06);
      wr(OFF_LIMIT, 4);
      wr(OFF_REFILL, 2);
      cmd(OP_REWIND, 9'h0);
      cmd(OP_RUN, 9'h0);
      rd(OFF_RUNST);
      chk("run empty", 32'(PS_STARVE), q);
      cmd(OP_OPEN, 9'h0);
      settle();
      chk("open request", 1, req);
      chk("full bits", 32'hd, full);
      // Load past the limit with random line lengths
      for (int k = 0; k < 5; k++) begin
         rnd = lfsr(rnd);
         load(int'(rnd[1:0]) + 1);
         settle();
         chk("request", want(lines, 4), req);
         chk("request_n", !want(lines, 4), req_n);
         rd(OFF_REMAIN);
         chk("remaining", lines, q);
      end
      wr(OFF_CS_SEL, 1);
      settle();
      chk("reselect", 0, req);
      // Drain; request comes back only under the refill threshold
      while (lines > 0) begin
         exec_line();
         settle();
         chk("refill request", want(lines, 2), req);
         rd(OFF_REMAIN);
         chk("remaining", lines, q);
      end
      run_line(9'h001);
      rd(OFF_RUNST);
      chk("starved", 3, q);
      rd(OFF_STATUS);
      chk("no error", 0, q[ST_ERR]);
      wr(OFF_SEG, 32'h10);
      load(2);
      settle();
      chk("blend", 1, blend_seen);
      rd(OFF_RUNST);
      chk("resumed", 2, q);
      cmd(OP_CLOSE, 9'h0);
      wr(OFF_WORD, 32'h1);
      rd(OFF_STATUS);
      chk("closed entry", 32'h4, q & 32'h5);
      exec_line();
      rd(OFF_REMAIN);
      chk("exec after close", 0, q);
      pulse('{1'b0, 2'd1, 9'h000, 1'b1, 1'b0});
      settle();
      chk("stop", 1, stops);
      chk("halted", 0, run[1]);
      // Quit and abort both return to ready; only abort stops motors
      cmd(OP_QUIT, 9'h0);
      rd(OFF_RUNST);
      chk("quit", 32'(PS_READY), q);
      cmd(OP_RUN, 9'h0);
      cmd(OP_ABORT, 9'h0);
      rd(OFF_RUNST);
      chk("abort", 32'(PS_READY), q);
      chk("abort stop", 2, stops);
      cmd(OP_FREE, 9'h0);
      rd(OFF_STATUS);
      chk("freed", 0, q & 32'h200);
      conclude();
   end
endmodule // rotary_program_ring_buffer_tb
`default_nettype wire
